// [src/touch_controller_serial_regs.sv]
// Serial register front end of the touch converter: SPI slave, two register
// pages and the conversion / touch-detect sequencer.
// Assumes sclk, ssN and mosi are synchronous to core_clk and the serial
// clock is several core cycles per half period.
`timescale 1ns/1ps
module touch_controller_serial_regs
  import touch_serial_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic sclk,
  input wire logic ssN,
  input wire logic mosi,
  output logic miso,
  output logic misoOe,
  input wire logic [11:0] adcSample,
  input wire logic touchSense,
  output logic touchAlertN,
  output logic resultReadyN,
  output logic yMinusGndOn,
  output logic xPlusAlertOn,
  output logic pullUpOn,
  output logic prechargeOn,
  output logic sampleOn,
  output logic [3:0] chanSel,
  output logic convClkEn
);
  // Edge detection of serial pins
  logic sclkQ_r; // Previous serial clock
  logic ssQ_r; // Previous select
  logic sclkRise;
  logic sclkFall;
  logic ssFallEdge;
  // Serial engine state
  logic armed_r; // Set by select falling edge
  logic haveCmd_r; // Command word taken
  logic isRead_r;
  logic [3:0] page_r;
  logic [6:0] ptr_r; // Index; PAGE_WORDS means past end
  logic [3:0] bitCnt_r;
  logic [14:0] rxShift_r;
  logic [15:0] txWord_r;
  logic [15:0] rxWord;
  logic wordDone;
  logic [6:0] ptrStep;
  logic resultRead; // Host fetched a result word
  // Register storage
  logic [11:0] results_r [0:10]; // Data page results
  logic [7:0] contrastValue_r;
  logic [15:0] convCtl_r;
  logic [15:0] contrastCtl_r;
  logic [15:0] vsrcCtl_r;
  logic [15:0] restartCtl_r;
  logic [15:0] setupCtl_r;
  logic startReq_r; // One-cycle start of a conversion
  // Timing
  logic [24:0] tickAcc_r;
  logic [25:0] tickSum;
  logic intTick; // 8MHz enable
  logic [2:0] divCnt_r;
  logic convTick;
  // Sequencer
  seq_e seq_r;
  seq_e seqNxt;
  logic [7:0] seqCnt_r;
  logic [7:0] seqLen;
  logic [4:0] resBits;
  logic seqStep;
  logic seqLast;
  logic busy;

  // Read decode shared by command fetch and auto-increment fetch
  function automatic logic [15:0] readWord(input logic [3:0] pg,
                                            input logic [6:0] idx);
    logic [15:0] w;
    w = WORD_ONES;
    if (idx >= PAGE_WORDS) begin
      w = WORD_ONES;
    end else if (pg == PAGE_DATA) begin
      if (idx == IDX_RSVD_ZERO || idx == IDX_ALL_CLEAR) begin
        w = WORD_ZERO;
      end else if (idx <= IDX_RESULT_LAST) begin
        w = {4'h0, results_r[idx[3:0]]};
      end else if (idx == IDX_CONTRAST_VALUE) begin
        w = {8'h00, contrastValue_r};
      end
    end else if (pg == PAGE_CTRL) begin
      case (idx)
        IDX_CONV_CTL: w = {busy, convCtl_r[14:0]};
        IDX_CONTRAST_CTL: w = contrastCtl_r;
        IDX_VSRC: w = vsrcCtl_r;
        IDX_RESTART: w = restartCtl_r;
        IDX_SETUP: w = setupCtl_r;
        default: w = WORD_ZERO; // Reserved control words
      endcase
    end
    return w;
  endfunction
  // Edge detectors; pins are taken as synchronous, so one stage suffices
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sclkQ_r <= 1'b0;
      ssQ_r <= 1'b1;
    end else begin
      sclkQ_r <= sclk;
      ssQ_r <= ssN;
    end
  end
  // Idle low clock: rising edge drives, falling edge samples
  assign sclkRise = sclk & ~sclkQ_r;
  assign sclkFall = ~sclk & sclkQ_r;
  assign ssFallEdge = ~ssN & ssQ_r;
  assign rxWord = {rxShift_r, mosi};
  assign wordDone = armed_r & ~ssN & sclkFall & (bitCnt_r == LAST_BIT);
  // Pointer saturates one past the page end so extra reads give ones
  assign ptrStep = (ptr_r < PAGE_WORDS) ? ptr_r + 7'h01 : ptr_r;
  // Serial shift engine and pointer
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      armed_r <= 1'b0;
      haveCmd_r <= 1'b0;
      isRead_r <= 1'b0;
      page_r <= PAGE_DATA;
      ptr_r <= 7'h00;
      bitCnt_r <= 4'h0;
      rxShift_r <= 15'h0000;
      txWord_r <= WORD_ZERO;
    end else if (ssN) begin
      // Select high aborts any partial word
      armed_r <= 1'b0;
      haveCmd_r <= 1'b0;
      bitCnt_r <= 4'h0;
    end else begin
      if (ssFallEdge) begin
        armed_r <= 1'b1;
        bitCnt_r <= 4'h0;
      end
      if (armed_r && sclkFall) begin
        rxShift_r <= rxWord[14:0];
        bitCnt_r <= bitCnt_r + 4'h1;
      end
      if (wordDone && !haveCmd_r) begin
        // First word is always the command; low five bits ignored
        haveCmd_r <= 1'b1;
        isRead_r <= rxWord[CMD_DIR_BIT];
        page_r <= rxWord[CMD_PAGE_HI:CMD_PAGE_LO];
        ptr_r <= {1'b0, rxWord[CMD_IDX_HI:CMD_IDX_LO]};
        txWord_r <= readWord(rxWord[CMD_PAGE_HI:CMD_PAGE_LO],
                             {1'b0, rxWord[CMD_IDX_HI:CMD_IDX_LO]});
      end else if (wordDone) begin
        ptr_r <= ptrStep;
        txWord_r <= readWord(page_r, ptrStep);
      end
    end
  end
  // Result ready clears once the host has read a result word
  assign resultRead = wordDone & haveCmd_r & isRead_r &
                      (page_r == PAGE_DATA) & (ptr_r <= IDX_RESULT_LAST);
  // MISO drive: a new bit on each rising serial edge
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      miso <= 1'b0;
      misoOe <= 1'b0;
    end else begin
      misoOe <= ~ssN & armed_r;
      if (ssN) begin
        miso <= 1'b0;
      end else if (armed_r && sclkRise) begin
        // Command word time returns zeros; reads return the fetched word
        miso <= haveCmd_r & isRead_r & txWord_r[LAST_BIT - bitCnt_r];
      end
    end
  end
  // Register writes, soft restart and conversion start
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      contrastValue_r <= CONTRAST_RESET;
      convCtl_r <= WORD_ZERO;
      contrastCtl_r <= WORD_ZERO;
      vsrcCtl_r <= WORD_ZERO;
      restartCtl_r <= WORD_ZERO;
      setupCtl_r <= WORD_ZERO;
      startReq_r <= 1'b0;
    end else begin
      startReq_r <= 1'b0;
      if (wordDone && haveCmd_r && !isRead_r) begin
        if (page_r == PAGE_DATA && ptr_r == IDX_CONTRAST_VALUE) begin
          contrastValue_r <= rxWord[7:0];
        end else if (page_r == PAGE_CTRL) begin
          case (ptr_r)
            IDX_CONV_CTL: begin
              convCtl_r <= rxWord;
              startReq_r <= rxWord[CC_START];
            end
            IDX_CONTRAST_CTL: contrastCtl_r <= rxWord;
            IDX_VSRC: vsrcCtl_r <= rxWord;
            IDX_RESTART: begin
              // Key value returns control settings to reset state
              if (rxWord == RESTART_KEY) begin
                contrastValue_r <= CONTRAST_RESET;
                convCtl_r <= WORD_ZERO;
                contrastCtl_r <= WORD_ZERO;
                vsrcCtl_r <= WORD_ZERO;
                setupCtl_r <= WORD_ZERO;
              end
              restartCtl_r <= rxWord;
            end
            IDX_SETUP: setupCtl_r <= rxWord;
            default: ; // Reserved words ignore writes
          endcase
        end
      end
    end
  end
  // Internal 8MHz enable from the 10MHz clock by phase accumulation;
  // it never depends on the converter divider
  assign tickSum = {1'b0, tickAcc_r} + {1'b0, INT_HZ_V};
  assign intTick = tickSum >= {1'b0, CORE_HZ_V};

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tickAcc_r <= 25'h0000000;
    end else if (intTick) begin
      tickAcc_r <= 25'(tickSum - {1'b0, CORE_HZ_V});
    end else begin
      tickAcc_r <= tickSum[24:0];
    end
  end
  // Conversion clock: internal tick divided by 1, 2, 4 or 8
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      divCnt_r <= 3'h0;
    end else if (intTick) begin
      divCnt_r <= divCnt_r + 3'h1;
    end
  end

  always_comb begin
    case (convCtl_r[CC_DIV_HI:CC_DIV_LO])
      2'h0: convTick = intTick;
      2'h1: convTick = intTick & (divCnt_r[0] == 1'b1);
      2'h2: convTick = intTick & (divCnt_r[1:0] == 2'h3);
      default: convTick = intTick & (divCnt_r == 3'h7);
    endcase
  end
  // Resolution picks the number of conversion clocks
  always_comb begin
    case (convCtl_r[CC_RES_HI:CC_RES_LO])
      RES_8: resBits = BITS_8;
      RES_10: resBits = BITS_10;
      default: resBits = BITS_12;
    endcase
  end
  // Length of the current sequencer phase in ticks
  always_comb begin
    case (seq_r)
      SEQ_PRECHG: seqLen = 8'(convLen(setupCtl_r[SC_PRE_HI:SC_PRE_LO]));
      SEQ_SENSE: seqLen = 8'(convLen(setupCtl_r[SC_SENSE_HI:SC_SENSE_LO]));
      SEQ_STAB: seqLen = 8'(convLen(convCtl_r[CC_STAB_HI:CC_STAB_LO]));
      SEQ_SAMPLE: seqLen = SAMPLE_TICKS;
      SEQ_CONV: seqLen = {3'h0, resBits};
      default: seqLen = 8'h00;
    endcase
  end

  // Code of three bits scaled to ticks; code zero still takes one tick
  function automatic logic [7:0] convLen(input logic [2:0] code);
    logic [7:0] n;
    n = 8'(code) * 8'(STEP_TICKS);
    if (n == 8'h00) begin
      n = 8'h01;
    end
    return n;
  endfunction

  assign busy = (seq_r != SEQ_IDLE);
  assign seqStep = (seq_r == SEQ_CONV) ? convTick : intTick;
  assign seqLast = seqStep & (seqCnt_r >= seqLen - 8'h01);

  // Sequencer next state
  always_comb begin
    seqNxt = seq_r;
    case (seq_r)
      SEQ_IDLE: begin
        if (startReq_r) begin
          seqNxt = convCtl_r[CC_CHECK] ? SEQ_PRECHG : SEQ_STAB;
        end
      end
      SEQ_PRECHG: if (seqLast) seqNxt = SEQ_SENSE;
      SEQ_SENSE: begin
        // Pen lifted during the check: give up without a result
        if (seqLast) seqNxt = touchSense ? SEQ_STAB : SEQ_IDLE;
      end
      SEQ_STAB: if (seqLast) seqNxt = SEQ_SAMPLE;
      SEQ_SAMPLE: if (seqLast) seqNxt = SEQ_CONV;
      SEQ_CONV: if (seqLast) seqNxt = SEQ_DONE;
      SEQ_DONE: seqNxt = SEQ_IDLE;
      default: seqNxt = SEQ_IDLE;
    endcase
  end

  // Sequencer state and phase counter
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      seq_r <= SEQ_IDLE;
      seqCnt_r <= 8'h00;
    end else begin
      seq_r <= seqNxt;
      if (seqNxt != seq_r) begin
        seqCnt_r <= 8'h00;
      end else if (seqStep) begin
        seqCnt_r <= seqCnt_r + 8'h01;
      end
    end
  end

  // Result capture, right-justified to the chosen resolution
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i <= 10; i++) begin
        results_r[i] <= 12'h000;
      end
    end else if (seq_r == SEQ_DONE && chanSel <= IDX_RESULT_LAST[3:0]
                 && chanSel != IDX_RSVD_ZERO[3:0]) begin
      results_r[chanSel] <= adcSample >> (5'(BITS_12) - resBits);
    end
  end

  // Ready flag: a new result wins over a read in the same cycle
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      resultReadyN <= 1'b1;
    end else if (seq_r == SEQ_DONE) begin
      resultReadyN <= 1'b0;
    end else if (resultRead) begin
      resultReadyN <= 1'b1;
    end
  end

  // Panel switch matrix, registered from the sequencer state
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      yMinusGndOn <= 1'b1;
      xPlusAlertOn <= 1'b1;
      pullUpOn <= 1'b1;
      prechargeOn <= 1'b0;
      sampleOn <= 1'b0;
      touchAlertN <= 1'b1;
      convClkEn <= 1'b0;
    end else begin
      // Idle and sense phases use the detect path; measuring cuts it
      yMinusGndOn <= (seqNxt == SEQ_IDLE) | (seqNxt == SEQ_SENSE);
      xPlusAlertOn <= (seqNxt == SEQ_IDLE) | (seqNxt == SEQ_SENSE);
      pullUpOn <= (seqNxt == SEQ_IDLE) | (seqNxt == SEQ_SENSE);
      prechargeOn <= (seqNxt == SEQ_PRECHG);
      sampleOn <= (seqNxt == SEQ_SAMPLE);
      touchAlertN <= ~(xPlusAlertOn & touchSense);
      convClkEn <= (seq_r == SEQ_CONV) & convTick;
    end
  end

  assign chanSel = convCtl_r[CC_CHAN_HI:CC_CHAN_LO];

  // Checks
  alert_disc_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (seq_r == SEQ_SAMPLE || seq_r == SEQ_CONV) |-> !xPlusAlertOn)
    else $error("alert path connected during measurement");
  idle_ground_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (seq_r == SEQ_IDLE) [*2] |-> (yMinusGndOn && xPlusAlertOn))
    else $error("power-down detect path not set");
  tick_rate_a: assert property (@(posedge core_clk) disable iff (!rstn)
    !intTick |=> intTick [*4])
    else $error("internal tick not 8 of 10 cycles");
  cmd_decode_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (wordDone && !haveCmd_r) |=>
      (ptr_r == {1'b0, $past(rxWord[10:5])} && haveCmd_r))
    else $error("command index not captured");
  ptr_step_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (wordDone && haveCmd_r && !ssN && $past(!ssN)) |=>
      ptr_r == $past(ptrStep))
    else $error("pointer did not advance");
  past_end_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (wordDone && haveCmd_r && ptr_r >= 7'h1f) |=> txWord_r == 16'hffff)
    else $error("read past page end not ones");
  miso_idle_a: assert property (@(posedge core_clk) disable iff (!rstn)
    ssN |=> (!misoOe && !miso && !haveCmd_r))
    else $error("serial output active without select");
  ready_set_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (seq_r == SEQ_CONV && seqLast) |-> ##2 !resultReadyN)
    else $error("result ready not asserted after conversion");
  precharge_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (seq_r == SEQ_SENSE) |-> (!prechargeOn && pullUpOn) or $past(seqLast))
    else $error("sense phase without pull-up");
  conv_tick_a: assert property (@(posedge core_clk) disable iff (!rstn)
    convTick |-> intTick)
    else $error("conversion tick outside internal tick");
endmodule // touch_controller_serial_regs

// [shared/touch_serial_pkg.sv]
// Package of constants for the touch converter serial register block.
// Assumes a single 10 MHz core clock; the SPI pins are synchronous to it.
package touch_serial_pkg;
  // Clock rates
  localparam int CORE_HZ = 10_000_000;
  localparam int INT_HZ = 8_000_000;
  localparam logic [24:0] CORE_HZ_V = 25'(CORE_HZ);
  localparam logic [24:0] INT_HZ_V = 25'(INT_HZ);
  // Command word layout
  localparam int CMD_DIR_BIT = 15;
  localparam int CMD_PAGE_HI = 14;
  localparam int CMD_PAGE_LO = 11;
  localparam int CMD_IDX_HI = 10;
  localparam int CMD_IDX_LO = 5;
  localparam logic [3:0] PAGE_DATA = 4'h0;
  localparam logic [3:0] PAGE_CTRL = 4'h1;
  localparam logic [6:0] PAGE_WORDS = 7'h20;
  localparam logic [3:0] LAST_BIT = 4'hf;
  // Data page indices
  localparam logic [6:0] IDX_RESULT_LAST = 7'h0a;
  localparam logic [6:0] IDX_RSVD_ZERO = 7'h04;
  localparam logic [6:0] IDX_CONTRAST_VALUE = 7'h0b;
  localparam logic [6:0] IDX_ALL_CLEAR = 7'h10;
  // Control page indices
  localparam logic [6:0] IDX_CONV_CTL = 7'h00;
  localparam logic [6:0] IDX_CONTRAST_CTL = 7'h02;
  localparam logic [6:0] IDX_VSRC = 7'h03;
  localparam logic [6:0] IDX_RESTART = 7'h04;
  localparam logic [6:0] IDX_SETUP = 7'h05;
  // Reset and fill values
  localparam logic [15:0] WORD_ONES = 16'hffff;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [7:0] CONTRAST_RESET = 8'h7f;
  localparam logic [15:0] RESTART_KEY = 16'hbb00;
  // converter_control fields
  localparam int CC_START = 15;
  localparam int CC_RES_HI = 14;
  localparam int CC_RES_LO = 13;
  localparam int CC_CHAN_HI = 12;
  localparam int CC_CHAN_LO = 9;
  localparam int CC_DIV_HI = 8;
  localparam int CC_DIV_LO = 7;
  localparam int CC_STAB_HI = 6;
  localparam int CC_STAB_LO = 4;
  localparam int CC_CHECK = 3;
  localparam logic [1:0] RES_12 = 2'h0;
  localparam logic [1:0] RES_8 = 2'h1;
  localparam logic [1:0] RES_10 = 2'h2;
  // setup_control fields
  localparam int SC_PRE_HI = 5;
  localparam int SC_PRE_LO = 3;
  localparam int SC_SENSE_HI = 2;
  localparam int SC_SENSE_LO = 0;
  // Timing in internal ticks; the BITS values count conversion clocks
  localparam logic [7:0] SAMPLE_TICKS = 8'h06;
  localparam int STEP_TICKS = 8;
  localparam logic [4:0] BITS_8 = 5'h08;
  localparam logic [4:0] BITS_10 = 5'h0a;
  localparam logic [4:0] BITS_12 = 5'h0c;
  // Converter sequencer
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b000,
    SEQ_PRECHG = 3'b001,
    SEQ_SENSE = 3'b010,
    SEQ_STAB = 3'b011,
    SEQ_SAMPLE = 3'b100,
    SEQ_CONV = 3'b101,
    SEQ_DONE = 3'b110
  } seq_e;
endpackage

// [test/spi_host_model.sv]
// Behavioural SPI host for the touch bench: clock polarity 0, phase 1.
// Assumes the device samples its pins on the 10 MHz core clock.
`timescale 1ns/1ps
module spi_host_model (
  input wire logic core_clk,
  output logic sclk,
  output logic ssN,
  output logic mosi,
  input wire logic miso
);
  int half = 4; // Core cycles per serial half period; raise for a slow host
  // Idle levels from time zero
  initial begin
    sclk = 1'b0;
    ssN = 1'b1;
    mosi = 1'b1;
  end
  // Step to just after a core clock edge
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Select falls well ahead of the first serial edge
  task automatic open();
    tick(1);
    ssN = 1'b0;
    tick(half);
  endtask
  // Released data line shows junk so stale bits cannot pass
  task automatic close();
    ssN = 1'b1;
    mosi = ~mosi;
    tick(half);
  endtask
  // One whole word, MSB first, both directions at once
  task automatic word(input logic [15:0] tx, output logic [15:0] rx);
    for (int i = 15; i >= 0; i--) begin
      sclk = 1'b1;
      mosi = tx[i];
      tick(half);
      sclk = 1'b0;
      rx[i] = miso;
      tick(half);
    end
  endtask
endmodule // spi_host_model

// [test/touch_controller_serial_regs_bench.sv]
// Self-checking bench for the touch serial register block.
// Assumes spi_host_model drives the serial pins; core clock is 10 MHz.
`timescale 1ns/1ps
module touch_controller_serial_regs_bench;
  import touch_serial_pkg::*;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic sclk, ssN, mosi, miso, misoOe;
  logic [11:0] adcSample = 12'h000;
  logic touchSense = 1'b0;
  logic touchAlertN, resultReadyN, yMinusGndOn, xPlusAlertOn, pullUpOn;
  logic prechargeOn, sampleOn, convClkEn;
  logic [3:0] chanSel;
  logic misoLine; // What the host sees on its data input
  logic [15:0] rx, d;
  logic sawSample = 1'b0; // Sample phase seen since last start
  int pulses = 0; // Conversion clock pulses since last start
  int preCount = 0; // Precharge cycles since last start
  int failCount = 0;
  int checkCount = 0;
  always #50 core_clk = ~core_clk;
  touch_controller_serial_regs dut (.core_clk(core_clk), .rstn(rstn),
    .sclk(sclk), .ssN(ssN), .mosi(mosi), .miso(miso), .misoOe(misoOe),
    .adcSample(adcSample), .touchSense(touchSense),
    .touchAlertN(touchAlertN), .resultReadyN(resultReadyN),
    .yMinusGndOn(yMinusGndOn), .xPlusAlertOn(xPlusAlertOn),
    .pullUpOn(pullUpOn), .prechargeOn(prechargeOn), .sampleOn(sampleOn),
    .chanSel(chanSel), .convClkEn(convClkEn));
  // A released data line shows the inverse, so a lost enable is caught
  assign misoLine = misoOe ? miso : ~miso;
  spi_host_model host (.core_clk(core_clk), .sclk(sclk), .ssN(ssN),
    .mosi(mosi), .miso(misoLine));
  // Watch the converter phases; the alert path must be off while sampling
  always @(posedge core_clk) begin
    if (sampleOn === 1'b1 && xPlusAlertOn !== 1'b0) begin
      failCount++;
      $display("BAD t=%0t got %h exp %h", $time, xPlusAlertOn, 1'b0);
    end
    if (sampleOn === 1'b1) sawSample = 1'b1;
    if (convClkEn === 1'b1) pulses++;
    if (prechargeOn === 1'b1) preCount++;
  end
  // Counts, verdict and end of run
  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", checkCount, failCount);
    if (failCount == 0 && checkCount > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Compare and report at once
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checkCount++;
    if (got !== exp) begin
      failCount++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Open a frame and send a command; the device answers zeros meanwhile
  task automatic cmd(input logic [15:0] c);
    host.open();
    host.word(c, rx);
    chk(rx, 16'h0000);
  endtask
  // Data page contents after reset, past the page end too
  function automatic logic [15:0] dataExp(input int i);
    if (i == 11) return 16'h007f;
    if (i <= 11 || i == 16) return 16'h0000;
    return 16'hffff;
  endfunction
  // Start a conversion and wait, bounded, for the ready flag
  task automatic conv(input logic [15:0] ctl, input bit mustEnd);
    int n;
    n = 0;
    pulses = 0;
    preCount = 0;
    sawSample = 1'b0;
    adcSample = 12'($urandom);
    cmd(16'h0800);
    host.word(ctl, rx);
    host.close();
    while (resultReadyN !== 1'b0 && n < 3000) begin
      host.tick(1);
      n++;
    end
    if (mustEnd && n >= 3000) begin
      failCount++;
      giveVerdict();
    end
  endtask
  // A result is the sample cut to its resolution, kept right-justified
  function automatic logic [15:0] resExp(input logic [4:0] bits);
    return 16'(adcSample >> (12 - int'(bits)));
  endfunction
  // Read one result word, check it and see the ready flag drop back
  task automatic readResult(input logic [5:0] idx, input logic [4:0] bits);
    cmd({5'h10, idx, 5'h00});
    host.word(16'h0000, rx);
    host.close();
    chk(rx & 16'hf000, 16'h0000);
    chk(rx, resExp(bits));
    chk(16'(resultReadyN), 16'h0001);
  endtask
  initial begin
    void'($urandom(32'hc6f6cdda));
    repeat (3) @(posedge core_clk);
    #1 rstn = 1'b1;
    host.tick(2);
    chk(16'({misoOe, miso, resultReadyN, yMinusGndOn, xPlusAlertOn,
      pullUpOn, prechargeOn, sampleOn, convClkEn}), 16'h0078);
    touchSense = 1'b1;
    host.tick(3);
    chk(16'(touchAlertN), 16'h0000);
    touchSense = 1'b0;
    host.tick(3);
    chk(16'(touchAlertN), 16'h0001);
    $display("idle test done");
    // Clocks while deselected must not count as a command
    host.word(16'h0160, rx);
    cmd(16'h8000 | 16'($urandom_range(0, 31)));
    for (int i = 0; i < 34; i++) begin
      host.word(16'($urandom), rx);
      chk(rx, dataExp(i));
    end
    host.close();
    $display("page read test done");
    for (int k = 0; k < 2; k++) begin
      host.half = 4 + 5 * k;
      d = 16'($urandom);
      cmd(16'h08a0);
      host.word(d, rx);
      host.word(~d, rx);
      host.close();
      cmd(16'h88a0);
      host.word(16'h0000, rx);
      chk(rx & 16'h003f, d & 16'h003f);
      host.word(16'h0000, rx);
      chk(rx, 16'h0000);
      host.close();
      cmd(16'h0160);
      host.word(d, rx);
      host.word(~d, rx);
      host.close();
      cmd(16'h8160);
      host.word(16'h0000, rx);
      chk(rx & 16'h00ff, d & 16'h00ff);
      host.word(16'h0000, rx);
      chk(rx, 16'hffff);
      host.close();
    end
    host.half = 4;
    for (int p = 2; p < 16; p++) begin
      cmd(16'h8000 | 16'(p << 11));
      host.word(16'h0000, rx);
      chk(rx, 16'hffff);
      host.close();
    end
    // Control words keep what was written until the restart key
    d = 16'($urandom);
    cmd(16'h0840);
    host.word(d, rx);
    host.word(~d, rx);
    host.close();
    cmd(16'h8840);
    host.word(16'h0000, rx);
    chk(rx, d);
    host.word(16'h0000, rx);
    chk(rx, ~d);
    host.close();
    cmd(16'h0880);
    host.word(RESTART_KEY, rx);
    host.close();
    cmd(16'h8840);
    for (int i = 0; i < 4; i++) begin
      host.word(16'h0000, rx);
      chk(rx, (i == 2) ? RESTART_KEY : WORD_ZERO);
    end
    host.close();
    cmd(16'h8160);
    host.word(16'h0000, rx);
    chk(rx, 16'(CONTRAST_RESET));
    host.close();
    $display("write and page test done");
    conv(16'ha000, 1'b1);
    chk(16'(pulses), 16'(BITS_8));
    chk(16'(sawSample), 16'h0001);
    readResult(6'h00, BITS_8);
    conv(16'hc080, 1'b1);
    chk(16'(pulses), 16'(BITS_10));
    readResult(6'h00, BITS_10);
    conv(16'h8b00, 1'b1);
    chk(16'(pulses), 16'(BITS_12));
    chk(16'(chanSel), 16'h0005);
    readResult(6'h05, BITS_12);
    $display("conversion test done");
    cmd(16'h08a0);
    host.word(16'h0012, rx);
    host.close();
    for (int t = 0; t < 2; t++) begin
      touchSense = t[0];
      conv(16'ha008, t[0]);
      chk(16'(preCount >= 19 && preCount <= 21), 16'h0001);
      chk(16'(resultReadyN), 16'(1 - t));
      chk(16'(pullUpOn), 16'h0001);
    end
    readResult(6'h00, BITS_8);
    $display("touch re-check test done");
    giveVerdict();
  end
endmodule // touch_controller_serial_regs_bench
